/* File: csv_pkg.sv */
/*
  Shared constants for the comparator sync and voltage reference control block:
  register offsets, bit positions, reset values and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package csv_pkg;

	// Byte offsets of the two registers.
	localparam logic [3:0] OFF_CMP_CTRL2 = 4'h0;
	localparam logic [3:0] OFF_VREF_CTRL = 4'h4;
	localparam logic [3:0] ADDR_MASK     = 4'hC;

	// Comparator control two fields.
	localparam int BIT_SYNC_SEL  = 0;
	localparam int BIT_GATE_SEL  = 1;
	localparam int BIT_HYST_EN   = 3;
	localparam int BIT_CLK_ALT   = 4;
	localparam logic [7:0] CMP_CTRL2_MASK  = 8'h1B;
	localparam logic [7:0] CMP_CTRL2_RESET = 8'h02;

	// Voltage reference control fields.
	localparam int BIT_LVL_LSB     = 0;
	localparam int BIT_LVL_MSB     = 3;
	localparam int BIT_FIXED_EN    = 4;
	localparam int BIT_RANGE_SEL   = 5;
	localparam int BIT_LADDER_EN   = 7;
	localparam logic [7:0] VREF_CTRL_MASK  = 8'hBF;
	localparam logic [7:0] VREF_CTRL_RESET = 8'h00;

	// Reference input selection codes.
	localparam logic [1:0] REF_GROUND = 2'h0;
	localparam logic [1:0] REF_FIXED  = 2'h1;
	localparam logic [1:0] REF_LADDER = 2'h2;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: csv_sync_stage.sv */
/*
  Comparator result sync stage: a three-flop input filter on the system clock,
  then a capture that updates only on a falling edge of the prescaled timer clock.
  Assumes the timer clock arrives as a level from another domain.
*/
`timescale 1ns/1ps
`default_nettype none
module csv_sync_stage (
	// Clock and reset
	input  wire  logic aclk,
	input  wire  logic aresetn,
	// Raw inputs
	input  wire  logic cmp_raw,
	input  wire  logic timer_clk_in,
	// Result
	output logic       cmp_held
);

	logic [2:0] tclk_r, tclk_nxt;
	logic       tlvl_r, tlvl_nxt;
	logic       held_r, held_nxt;
	logic       fall;

	// Three flops; a change counts only once the second and third agree.
	always_comb begin
		tclk_nxt = {tclk_r[1:0], timer_clk_in};
		tlvl_nxt = (tclk_r[1] == tclk_r[2]) ? tclk_r[2] : tlvl_r;
		fall     = tlvl_r & (tclk_r[1] == tclk_r[2]) & ~tclk_r[2];
		held_nxt = fall ? cmp_raw : held_r;
	end

	// Registers for the filter and the held sample.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tclk_r <= 3'h0;
			tlvl_r <= 1'h0;
			held_r <= 1'h0;
		end else begin
			tclk_r <= tclk_nxt;
			tlvl_r <= tlvl_nxt;
			held_r <= held_nxt;
		end
	end

	assign cmp_held = held_r;

endmodule
`default_nettype wire

/* File: csv_top.sv */
/*
  Comparator sync and voltage reference control register bank with an
  AXI4-Lite slave. Drives timer clock and gate selection, the comparator
  output path, hysteresis, and the reference multiplexer and ladder controls.
  Assumes the timer clock input is the prescaled timer clock from the timer.
*/
// What this block does
// - With sync select set, the comparator result is captured on each timer clock falling edge.
// - The capture uses the prescaled timer clock, not the undivided source.
// - The timer counts on rising edges while the sample updates on falling edges.
// - With sync select clear, the comparator result passes through uncaptured.
// - Clock alt select at bit 4 picks the system clock when set, the instruction clock when clear.
// - Gate source select at bit 1 picks the gate pin when set, the comparator output when clear.
// - Hysteresis enable at bit 3 turns hysteresis on; bits 7 to 5 and 2 read as zero.
// - Bit 6 of the reference register reads as zero and ignores writes.
// - Ladder enable at bit 7 routes the ladder to the reference input, else the fixed reference if bit 4 is set.
// - While ladder enable is low the ladder divider is powered down.
// - Range select at bit 5 picks the low range when set, the high range when clear.
// - A four-bit level code picks one of 16 ladder taps in the selected range.
// - The fixed reference is on when its bit 4 is set or the fast internal oscillator runs.
// - With both enables low, the reference input is tied to ground.
`timescale 1ns/1ps
`default_nettype none
module csv_top (
	// Clock and reset
	input  wire  logic        aclk,
	input  wire  logic        aresetn,
	// AXI4-Lite write address
	input  wire  logic        s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire  logic [3:0]  s_axi_awaddr,
	input  wire  logic [2:0]  s_axi_awprot,
	// AXI4-Lite write data
	input  wire  logic        s_axi_wvalid,
	output logic              s_axi_wready,
	input  wire  logic [31:0] s_axi_wdata,
	input  wire  logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic              s_axi_bvalid,
	input  wire  logic        s_axi_bready,
	output logic [1:0]        s_axi_bresp,
	// AXI4-Lite read address
	input  wire  logic        s_axi_arvalid,
	output logic              s_axi_arready,
	input  wire  logic [3:0]  s_axi_araddr,
	input  wire  logic [2:0]  s_axi_arprot,
	// AXI4-Lite read data
	output logic              s_axi_rvalid,
	input  wire  logic        s_axi_rready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	// Comparator and timer side
	input  wire  logic        cmp_result,
	input  wire  logic        timer_clk_prescaled,
	input  wire  logic        timer_gate_pin,
	input  wire  logic        high_freq_internal_osc,
	output logic              cmp_to_consumers,
	output logic              timer_gate,
	output logic              timer_clk_alt_select,
	output logic              hysteresis_enable,
	// Reference side
	output logic [1:0]        ref_input_select,
	output logic              ladder_power_down,
	output logic              ladder_range_select,
	output logic [3:0]        ladder_level_code,
	output logic              fixed_ref_on
);

	logic [7:0]  cc2_r, cc2_nxt;
	logic [7:0]  vrc_r, vrc_nxt;
	logic        aw_got_r, aw_got_nxt;
	logic        w_got_r, w_got_nxt;
	logic [3:0]  awaddr_r, awaddr_nxt;
	logic [7:0]  wdata_r, wdata_nxt;
	logic        wstrb0_r, wstrb0_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;
	logic        aw_take, w_take, do_write, ar_take;
	logic        cmp_held;
	logic        cmp_sel;
	logic        sync_sel;
	logic        ladder_en;
	logic        fixed_en;

	// Synchronised comparator sample, timed by the prescaled timer clock.
	csv_sync_stage u_sync (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.cmp_raw      (cmp_result),
		.timer_clk_in (timer_clk_prescaled),
		.cmp_held     (cmp_held)
	);

	// Handshakes: each address and data channel is taken once, in either order.
	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready  = ~w_got_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign aw_take  = s_axi_awvalid & s_axi_awready;
	assign w_take   = s_axi_wvalid & s_axi_wready;
	assign ar_take  = s_axi_arvalid & s_axi_arready;
	assign do_write = (aw_got_r | aw_take) & (w_got_r | w_take) & ~bvalid_r;

	// Write path and register storage.
	always_comb begin
		logic [3:0] a;
		logic [7:0] d;
		logic       s;
		a = aw_take ? s_axi_awaddr : awaddr_r;
		d = w_take ? s_axi_wdata[7:0] : wdata_r;
		s = w_take ? s_axi_wstrb[0] : wstrb0_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		awaddr_nxt = aw_take ? s_axi_awaddr : awaddr_r;
		wdata_nxt  = w_take ? s_axi_wdata[7:0] : wdata_r;
		wstrb0_nxt = w_take ? s_axi_wstrb[0] : wstrb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		cc2_nxt    = cc2_r;
		vrc_nxt    = vrc_r;
		if (aw_take) begin
			aw_got_nxt = 1'h1;
		end
		if (w_take) begin
			w_got_nxt = 1'h1;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'h0;
		end
		if (do_write) begin
			aw_got_nxt = 1'h0;
			w_got_nxt  = 1'h0;
			bvalid_nxt = 1'h1;
			bresp_nxt  = csv_pkg::RESP_OKAY;
			unique case (a & csv_pkg::ADDR_MASK)
				csv_pkg::OFF_CMP_CTRL2: begin
					if (s) begin
						cc2_nxt = d & csv_pkg::CMP_CTRL2_MASK;
					end
				end
				csv_pkg::OFF_VREF_CTRL: begin
					if (s) begin
						vrc_nxt = d & csv_pkg::VREF_CTRL_MASK;
					end
				end
				default: begin
					bresp_nxt = csv_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// Read path; unused upper bits read as zero.
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'h0;
		end
		if (ar_take) begin
			rvalid_nxt = 1'h1;
			rresp_nxt  = csv_pkg::RESP_OKAY;
			unique case (s_axi_araddr & csv_pkg::ADDR_MASK)
				csv_pkg::OFF_CMP_CTRL2: rdata_nxt = {24'h000000, cc2_r};
				csv_pkg::OFF_VREF_CTRL: rdata_nxt = {24'h000000, vrc_r};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = csv_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// State registers; the gate source bit comes up set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cc2_r    <= csv_pkg::CMP_CTRL2_RESET;
			vrc_r    <= csv_pkg::VREF_CTRL_RESET;
			aw_got_r <= 1'h0;
			w_got_r  <= 1'h0;
			awaddr_r <= 4'h0;
			wdata_r  <= 8'h00;
			wstrb0_r <= 1'h0;
			bvalid_r <= 1'h0;
			bresp_r  <= 2'h0;
			rvalid_r <= 1'h0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= 2'h0;
		end else begin
			cc2_r    <= cc2_nxt;
			vrc_r    <= vrc_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r  <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r  <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	// Comparator path; the raw path is combinational so it adds no latency.
	assign sync_sel         = cc2_r[csv_pkg::BIT_SYNC_SEL];
	assign cmp_sel          = sync_sel ? cmp_held : cmp_result;
	assign cmp_to_consumers = cmp_sel;
	assign timer_gate       = cc2_r[csv_pkg::BIT_GATE_SEL] ? timer_gate_pin : cmp_sel;
	assign timer_clk_alt_select = cc2_r[csv_pkg::BIT_CLK_ALT];
	assign hysteresis_enable    = cc2_r[csv_pkg::BIT_HYST_EN];

	// Reference multiplexer and ladder controls.
	assign ladder_en   = vrc_r[csv_pkg::BIT_LADDER_EN];
	assign fixed_en    = vrc_r[csv_pkg::BIT_FIXED_EN];
	assign fixed_ref_on = fixed_en | high_freq_internal_osc;
	assign ladder_power_down   = ~ladder_en;
	assign ladder_range_select = vrc_r[csv_pkg::BIT_RANGE_SEL];
	assign ladder_level_code   = vrc_r[csv_pkg::BIT_LVL_MSB:csv_pkg::BIT_LVL_LSB];
	// Ground only when both enables are clear; the oscillator does not lift it.
	assign ref_input_select = ladder_en ? csv_pkg::REF_LADDER :
		(fixed_en ? csv_pkg::REF_FIXED : csv_pkg::REF_GROUND);

endmodule
`default_nettype wire

/* File: csv_tmr_model.sv */
/*
  Partner model of the timer: a free-running prescaled timer clock and a counter.
  Assumes it shares aclk and aresetn with the block under test.
*/
`timescale 1ns/1ps
`default_nettype none
module csv_tmr_model #(parameter int HALF = 8) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Prescaled timer clock
	output logic      tclk
);
	logic [7:0]  div_r;
	logic [15:0] count_r;
	logic        tclk_q;
	// The divider stands in for the prescaler, so the block only ever sees the divided clock.
	always_ff @(posedge aclk) begin
		div_r <= (!aresetn || div_r == 8'(HALF - 1)) ? 8'h00 : div_r + 8'h01;
		if (!aresetn)
			tclk <= 1'b0;
		else if (div_r == 8'(HALF - 1))
			tclk <= ~tclk;
	end
	// Counting on rising edges keeps clear of the falling-edge sample in the block.
	always_ff @(posedge aclk) begin
		tclk_q <= tclk;
		if (!aresetn)
			count_r <= 16'h0000;
		else if (tclk && !tclk_q)
			count_r <= count_r + 16'h0001;
	end
endmodule
`default_nettype wire

/* File: csv_top_sva.sv */
/*
  Checker for the block: reference routing and bus handshake relations.
  Assumes it is bound to csv_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module csv_top_sva (
	// Clock, reset and bus
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// Block side
	input wire logic        timer_gate_pin,
	input wire logic        high_freq_internal_osc,
	input wire logic        cmp_to_consumers,
	input wire logic        timer_gate,
	input wire logic [1:0]  ref_input_select,
	input wire logic        ladder_power_down,
	input wire logic        fixed_ref_on
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write channels taken together, then the response.
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_pd; ladder_power_down == (ref_input_select != csv_pkg::REF_LADDER); endproperty
	a_pd: assert property (p_pd) else $error("ladder power down wrong");
	property p_gnd; ref_input_select == csv_pkg::REF_GROUND && !high_freq_internal_osc |-> !fixed_ref_on; endproperty
	a_gnd: assert property (p_gnd) else $error("ground with fixed on");
	property p_osc; high_freq_internal_osc |-> fixed_ref_on; endproperty
	a_osc: assert property (p_osc) else $error("osc did not force fixed");
	property p_fix; ref_input_select == csv_pkg::REF_FIXED |-> fixed_ref_on; endproperty
	a_fix: assert property (p_fix) else $error("fixed routed while off");
	property p_gate; timer_gate == timer_gate_pin || timer_gate == cmp_to_consumers; endproperty
	a_gate: assert property (p_gate) else $error("gate source wrong");
	property p_b; s_wr |=> s_axi_bvalid; endproperty
	a_b: assert property (p_b) else $error("no write response");
	property p_r; s_rd |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000; endproperty
	a_r: assert property (p_r) else $error("read late or high bits set");
	property p_bref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_bref: assert property (p_bref) else $error("write taken during response");
	property p_rref; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rref: assert property (p_rref) else $error("read taken during response");
endmodule
bind csv_top csv_top_sva u_csv_top_sva (.*);
`default_nettype wire

/* File: test_csv_top.sv */
/*
  Testbench: register table rows, then reset, strobe, sync and gate cases.
  Assumes the partner model supplies the prescaled timer clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_csv_top;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wr, bv, arr, rv, cmp = 0, tclk, pin = 0, osc = 0, cmpo, gate, alt, hys, pd, rng, fx;
	logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'hF, lvl;
	logic [31:0] wd = 32'h0, rd;
	logic [1:0] br, rr, sel, r1, r2;
	logic [32:0] rows [8];
	logic [31:0] v;
	int miscompares = 0, tests_run = 0, n;
	csv_top u_csv_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .cmp_result(cmp), .timer_clk_prescaled(tclk), .timer_gate_pin(pin),
		.high_freq_internal_osc(osc), .cmp_to_consumers(cmpo), .timer_gate(gate),
		.timer_clk_alt_select(alt), .hysteresis_enable(hys), .ref_input_select(sel),
		.ladder_power_down(pd), .ladder_range_select(rng), .ladder_level_code(lvl),
		.fixed_ref_on(fx));
	csv_tmr_model #(.HALF(8)) u_csv_tmr_model (.aclk(aclk), .aresetn(aresetn), .tclk(tclk));
	// A 4 ns clock.
	initial begin
		forever #2 aclk = ~aclk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// A wait that runs out counts as a mismatch and ends the run.
	task automatic give_up(input int k);
		if (k >= 50) begin
			miscompares++;
			give_verdict();
		end
	endtask
	// Write: both channels offered together, each released once taken.
	task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge aclk);
		{awv, wv, bry, awa, wd, ws} <= {3'h7, a, 24'h000000, d, s};
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (bv) break;
		end
		r1 = br;
		bry <= 1'b0;
		give_up(n);
	endtask
	task automatic axr(input logic [3:0] a);
		@(posedge aclk);
		{arv, rry, ara} <= {2'h3, a};
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		{v, r2} = {rd, rr};
		rry <= 1'b0;
		give_up(n);
	endtask
	// The held sample moves only a few cycles after a falling timer clock edge.
	task automatic fall;
		for (n = 0; n < 50 && !(tclk === 1'b1); n++) @(posedge aclk);
		give_up(n);
		for (n = 0; n < 50 && !(tclk === 1'b0); n++) @(posedge aclk);
		give_up(n);
		repeat (6) @(posedge aclk);
	endtask
	initial begin
		rows = '{{4'h4, 8'hFF, 8'hBF, 2'h0, 11'h13F}, {4'h4, 8'h40, 8'h00, 2'h0, 11'h040},
			{4'h4, 8'h15, 8'h15, 2'h0, 11'h0CB}, {4'h4, 8'hA0, 8'hA0, 2'h0, 11'h120},
			{4'h0, 8'hFF, 8'h1B, 2'h0, 11'h720}, {4'h0, 8'h00, 8'h00, 2'h0, 11'h120},
			{4'h4, 8'h20, 8'h20, 2'h0, 11'h060}, {4'h8, 8'hFF, 8'h00, 2'h2, 11'h060}};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			axw(rows[i][32:29], rows[i][28:21], 4'hF);
			chk("bresp", rows[i][12:11], r1);
			axr(rows[i][32:29]);
			chk("rdata", rows[i][20:13], v);
			chk("rresp", rows[i][12:11], r2);
			chk("outs", rows[i][10:0], {alt, hys, sel, pd, rng, lvl, fx});
		end
		// Software clamp: enable clear, low range, code zero leaves the divider dark.
		axw(4'h4, 8'h20, 4'hF);
		chk("clamp", 7'h10, {sel, pd, lvl});
		osc <= 1'b1;
		@(posedge aclk);
		chk("osc", 3'h1, {sel, fx});
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(4'h0);
		chk("ctrl2 reset", 8'h02, v);
		axr(4'h4);
		chk("vref reset", 8'h00, v);
		axw(4'h0, 8'h01, 4'h0);
		chk("no strobe resp", 2'h0, r1);
		axr(4'h0);
		chk("no strobe", 8'h02, v);
		axw(4'h0, 8'h01, 4'hF);
		fall();
		cmp <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("held", 2'h0, {cmpo, gate});
		fall();
		chk("sampled", 2'h3, {cmpo, gate});
		axw(4'h0, 8'h00, 4'hF);
		cmp <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("direct", 2'h0, {cmpo, gate});
		axw(4'h0, 8'h02, 4'hF);
		pin <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("gate pin", 1'b1, gate);
		give_verdict();
	end
endmodule
`default_nettype wire
